/* File: verilog/pin_mux_pkg.sv */
// Purpose: constants for the pin function selector block
// Assumes: byte-wide register port, offsets as byte addresses
// Notes:   selector codes for pins 8 to 12
package pin_mux_pkg;
    localparam int          ADDR_W          = 9;
    localparam int          DATA_W          = 8;
    localparam int          SEL_W           = 4;
    localparam int          NUM_PINS        = 5;
    localparam logic [8:0]  OFS_SEL_8_9     = 9'h1A4;
    localparam logic [8:0]  OFS_SEL_10_11   = 9'h1A5;
    localparam logic [8:0]  OFS_SEL_12      = 9'h1A6;
    localparam logic [7:0]  SEL_RESET       = 8'h00;
    localparam logic [7:0]  RDATA_IDLE      = 8'h00;
    localparam logic [4:0]  PIN_RESET       = 5'h00;
    localparam int          LO_FIELD_LSB    = 0;
    localparam int          HI_FIELD_LSB    = 4;
    localparam logic [3:0]  CODE_GPIO       = 4'h0;
    localparam logic [3:0]  CODE_INT0       = 4'h1;
    localparam logic [3:0]  CODE_ALT_A      = 4'h4;
    localparam logic [3:0]  CODE_ALT_B      = 4'h5;
    localparam logic [3:0]  CODE_ALT_C      = 4'h6;
endpackage

/* File: verilog/pin_func_decode.sv */
// Purpose: one pin's function multiplexer
// Assumes: selector is held in a register upstream
// Notes:   reserved codes fall back to general-purpose I/O
module pin_func_decode (
    input  wire logic [3:0] sel,
    input  wire logic       gpio_out,
    input  wire logic       gpio_oe,
    input  wire logic       interrupt_output_zero,
    input  wire logic       alt_control_out_a,
    input  wire logic       alt_control_out_b,
    input  wire logic       alt_control_out_c,
    output logic            pin_out,
    output logic            pin_oe
);
    always_comb
    begin
        pin_out = gpio_out;
        pin_oe  = gpio_oe;
        case (sel)
            pin_mux_pkg::CODE_GPIO:
            begin
                pin_out = gpio_out;
                pin_oe  = gpio_oe;
            end
            pin_mux_pkg::CODE_INT0:
            begin
                pin_out = interrupt_output_zero;
                pin_oe  = 1'b1;
            end
            pin_mux_pkg::CODE_ALT_A:
            begin
                pin_out = alt_control_out_a;
                pin_oe  = 1'b1;
            end
            pin_mux_pkg::CODE_ALT_B:
            begin
                pin_out = alt_control_out_b;
                pin_oe  = 1'b1;
            end
            pin_mux_pkg::CODE_ALT_C:
            begin
                pin_out = alt_control_out_c;
                pin_oe  = 1'b1;
            end
            // software must not write these; safest to stay on gpio
            default:
            begin
                pin_out = gpio_out;
                pin_oe  = gpio_oe;
            end
        endcase
    end
endmodule

/* File: verilog/gpio_pin_function_select.sv */
// Purpose: pin function selection for port pins 8 to 12
// Assumes: single clock, synchronous active-high reset
// Notes:   outputs registered, one cycle after selector or source change
//
// Functional notes
// - register 0x1A4 selects pins 8 and 9
// - register 0x1A5 selects pins 10 and 11
// - register 0x1A6 selects pin 12, upper zero
// - all selectors reset to 0x00, gpio
// - decode gpio, int0, alt a, b, c
//
// Added by the designer: the address-and-strobe port.
module gpio_pin_function_select (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [8:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [4:0] gpio_out,
    input  wire logic [4:0] gpio_oe,
    input  wire logic       interrupt_output_zero,
    input  wire logic       alt_control_out_a,
    input  wire logic       alt_control_out_b,
    input  wire logic       alt_control_out_c,
    output logic      [4:0] pin_out,
    output logic      [4:0] pin_oe
);
    // selector storage; the pin 12 register keeps only its low field
    logic [7:0]  sel_8_9_q;
    logic [7:0]  sel_8_9_d;
    logic [7:0]  sel_10_11_q;
    logic [7:0]  sel_10_11_d;
    logic [3:0]  sel_12_q;
    logic [3:0]  sel_12_d;

    // read data and registered pin stage
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;
    logic [4:0]  pin_out_q;
    logic [4:0]  pin_out_d;
    logic [4:0]  pin_oe_q;
    logic [4:0]  pin_oe_d;

    // address decode
    logic        hit_8_9;
    logic        hit_10_11;
    logic        hit_12;

    // write enables
    logic        wr_8_9;
    logic        wr_10_11;
    logic        wr_12;

    // read-back views of the three registers
    logic [7:0]  view_8_9;
    logic [7:0]  view_10_11;
    logic [7:0]  view_12;
    logic [7:0]  rd_mux;

    // one 4-bit selector per pin
    logic [3:0]  pin8_func_field;
    logic [3:0]  pin9_func_field;
    logic [3:0]  pin10_func_field;
    logic [3:0]  pin11_func_field;
    logic [3:0]  pin12_func_field;

    // per-pin multiplexer results, ahead of the output register
    logic [4:0]  mux_out;
    logic [4:0]  mux_oe;

    // full 9-bit compare, so no alias above the map hits a register
    function automatic logic addr_is(
        input logic [8:0] addr,
        input logic [8:0] ofs
    );
    begin
        addr_is = (addr == ofs);
    end
    endfunction

    // low and high selector fields of a register byte
    function automatic logic [3:0] lo_field(
        input logic [7:0] value
    );
    begin
        lo_field = value[pin_mux_pkg::LO_FIELD_LSB +: pin_mux_pkg::SEL_W];
    end
    endfunction

    function automatic logic [3:0] hi_field(
        input logic [7:0] value
    );
    begin
        hi_field = value[pin_mux_pkg::HI_FIELD_LSB +: pin_mux_pkg::SEL_W];
    end
    endfunction

    // next value of a selector byte: replaced whole on a write
    function automatic logic [7:0] next_byte(
        input logic       en,
        input logic [7:0] new_value,
        input logic [7:0] old_value
    );
    begin
        next_byte = en ? new_value : old_value;
    end
    endfunction

    // pin 12 register reads its unused upper half as zero
    function automatic logic [7:0] pad_upper(
        input logic [3:0] field
    );
    begin
        pad_upper = {4'h0, field};
    end
    endfunction

    // address decode
    assign hit_8_9   = addr_is(reg_addr, pin_mux_pkg::OFS_SEL_8_9);
    assign hit_10_11 = addr_is(reg_addr, pin_mux_pkg::OFS_SEL_10_11);
    assign hit_12    = addr_is(reg_addr, pin_mux_pkg::OFS_SEL_12);

    // writes to any other address are ignored
    assign wr_8_9   = reg_wr && hit_8_9;
    assign wr_10_11 = reg_wr && hit_10_11;
    assign wr_12    = reg_wr && hit_12;

    assign sel_8_9_d   = next_byte(wr_8_9, reg_wdata, sel_8_9_q);
    assign sel_10_11_d = next_byte(wr_10_11, reg_wdata, sel_10_11_q);
    // upper bits dropped, so they can never read back set
    assign sel_12_d    = wr_12 ? lo_field(reg_wdata) : sel_12_q;

    // selector fields, one per pin
    assign pin8_func_field  = lo_field(sel_8_9_q);
    assign pin9_func_field  = hi_field(sel_8_9_q);
    assign pin10_func_field = lo_field(sel_10_11_q);
    assign pin11_func_field = hi_field(sel_10_11_q);
    assign pin12_func_field = sel_12_q;

    // read-back views; unmapped addresses read zero
    assign view_8_9   = sel_8_9_q;
    assign view_10_11 = sel_10_11_q;
    assign view_12    = pad_upper(sel_12_q);
    assign rd_mux     = hit_8_9   ? view_8_9   :
                        hit_10_11 ? view_10_11 :
                        hit_12    ? view_12    :
                                    pin_mux_pkg::RDATA_IDLE;

    // read data stand in each cycle after a cycle with reg_rd high, zero otherwise
    assign rdata_d    = reg_rd ? rd_mux : pin_mux_pkg::RDATA_IDLE;

    // pins take a registered copy of the multiplexer result
    assign pin_out_d  = mux_out;
    assign pin_oe_d   = mux_oe;

    // one decoder per pin; all five share the function sources
    // pin 8: low field of the first register
    pin_func_decode u_pin8 (
        .sel                   (pin8_func_field),
        .gpio_out              (gpio_out[0]),
        .gpio_oe               (gpio_oe[0]),
        .interrupt_output_zero (interrupt_output_zero),
        .alt_control_out_a     (alt_control_out_a),
        .alt_control_out_b     (alt_control_out_b),
        .alt_control_out_c     (alt_control_out_c),
        .pin_out               (mux_out[0]),
        .pin_oe                (mux_oe[0])
    );

    // pin 9: high field of the first register
    pin_func_decode u_pin9 (
        .sel                   (pin9_func_field),
        .gpio_out              (gpio_out[1]),
        .gpio_oe               (gpio_oe[1]),
        .interrupt_output_zero (interrupt_output_zero),
        .alt_control_out_a     (alt_control_out_a),
        .alt_control_out_b     (alt_control_out_b),
        .alt_control_out_c     (alt_control_out_c),
        .pin_out               (mux_out[1]),
        .pin_oe                (mux_oe[1])
    );

    // pin 10: low field of the second register
    pin_func_decode u_pin10 (
        .sel                   (pin10_func_field),
        .gpio_out              (gpio_out[2]),
        .gpio_oe               (gpio_oe[2]),
        .interrupt_output_zero (interrupt_output_zero),
        .alt_control_out_a     (alt_control_out_a),
        .alt_control_out_b     (alt_control_out_b),
        .alt_control_out_c     (alt_control_out_c),
        .pin_out               (mux_out[2]),
        .pin_oe                (mux_oe[2])
    );

    // pin 11: high field of the second register
    pin_func_decode u_pin11 (
        .sel                   (pin11_func_field),
        .gpio_out              (gpio_out[3]),
        .gpio_oe               (gpio_oe[3]),
        .interrupt_output_zero (interrupt_output_zero),
        .alt_control_out_a     (alt_control_out_a),
        .alt_control_out_b     (alt_control_out_b),
        .alt_control_out_c     (alt_control_out_c),
        .pin_out               (mux_out[3]),
        .pin_oe                (mux_oe[3])
    );

    // pin 12: low field of the third register
    pin_func_decode u_pin12 (
        .sel                   (pin12_func_field),
        .gpio_out              (gpio_out[4]),
        .gpio_oe               (gpio_oe[4]),
        .interrupt_output_zero (interrupt_output_zero),
        .alt_control_out_a     (alt_control_out_a),
        .alt_control_out_b     (alt_control_out_b),
        .alt_control_out_c     (alt_control_out_c),
        .pin_out               (mux_out[4]),
        .pin_oe                (mux_oe[4])
    );

    // selector registers, all cleared so every pin starts as gpio
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sel_8_9_q <= pin_mux_pkg::SEL_RESET;
        end
        else
        begin
            sel_8_9_q <= sel_8_9_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sel_10_11_q <= pin_mux_pkg::SEL_RESET;
        end
        else
        begin
            sel_10_11_q <= sel_10_11_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sel_12_q <= lo_field(pin_mux_pkg::SEL_RESET);
        end
        else
        begin
            sel_12_q <= sel_12_d;
        end
    end

    // read data register
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rdata_q <= pin_mux_pkg::RDATA_IDLE;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // registered pins trade one cycle latency for glitch-free outputs
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pin_out_q <= pin_mux_pkg::PIN_RESET;
        end
        else
        begin
            pin_out_q <= pin_out_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pin_oe_q <= pin_mux_pkg::PIN_RESET;
        end
        else
        begin
            pin_oe_q <= pin_oe_d;
        end
    end

    // top outputs come straight from flip-flops
    assign reg_rdata = rdata_q;
    assign pin_out   = pin_out_q;
    assign pin_oe    = pin_oe_q;
endmodule

/* File: bench/pin_sel_asserts.sv */
// Purpose: port checker for pin function selection
// Assumes: pins registered one cycle after their sources
// Notes:   shadow copies of two selectors, built from port writes
module pin_sel_asserts (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [4:0] gpio_out,
    input wire logic [4:0] gpio_oe,
    input wire logic       interrupt_output_zero,
    input wire logic       alt_control_out_c,
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] sel8_q;
    logic [3:0] sel12_q;
    wire        hit_lo = reg_addr == pin_mux_pkg::OFS_SEL_8_9;
    wire        hit_md = reg_addr == pin_mux_pkg::OFS_SEL_10_11;
    wire        hit_hi = reg_addr == pin_mux_pkg::OFS_SEL_12;
    // write-only shadows: reads never disturb the selectors
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sel8_q  <= 4'h0;
            sel12_q <= 4'h0;
        end
        else if (reg_wr && hit_lo)
            sel8_q  <= reg_wdata[3:0];
        else if (reg_wr && hit_hi)
            sel12_q <= reg_wdata[3:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_reset_clears: assert property ($past(reset) |->
        reg_rdata == 8'h00 && pin_oe == 5'h00) else $error("not cleared");
    a_read_back: assert property (reg_wr && (hit_lo || hit_md)
        ##1 !reg_wr && $stable(reg_addr) ##1 reg_rd && $stable(reg_addr)
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("readback");
    a_upper_zero: assert property ($past(reg_rd) &&
        $past(hit_hi) |-> reg_rdata[7:4] == 4'h0) else $error("upper");
    a_unmapped_zero: assert property (reg_rd && !hit_lo && !hit_md
        && !hit_hi |=> reg_rdata == 8'h00) else $error("unmapped");
    a_int0_route: assert property (sel8_q == pin_mux_pkg::CODE_INT0
        |=> pin_out[0] == $past(interrupt_output_zero) && pin_oe[0])
        else $error("int0 route");
    a_gpio_route: assert property (sel8_q == pin_mux_pkg::CODE_GPIO
        |=> pin_out[0] == $past(gpio_out[0])
        && pin_oe[0] == $past(gpio_oe[0])) else $error("gpio route");
    a_alt_c_route: assert property (sel12_q == pin_mux_pkg::CODE_ALT_C
        |=> pin_out[4] == $past(alt_control_out_c) && pin_oe[4])
        else $error("alt c route");
endmodule
bind gpio_pin_function_select pin_sel_asserts chk (.clk(clk),
    .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_out(pin_out),
    .interrupt_output_zero(interrupt_output_zero), .pin_oe(pin_oe),
    .alt_control_out_c(alt_control_out_c));

/* File: bench/gpio_pin_function_select_test.sv */
// Purpose: register and pin routing test for pin function selection
// Assumes: 125 MHz clock, synchronous reset
// Notes:   src packs sources as c, b, a, int0 from msb down
module gpio_pin_function_select_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [4:0] gpio_out = 5'h00;
    logic [4:0] gpio_oe = 5'h00;
    logic [3:0] src = 4'h0;
    logic [4:0] pin_out;
    logic [4:0] pin_oe;
    int         n_errors = 0;
    int         checked = 0;
    always #4 clk = ~clk;
    gpio_pin_function_select uut (.clk(clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .interrupt_output_zero(src[0]),
        .alt_control_out_a(src[1]), .alt_control_out_b(src[2]),
        .alt_control_out_c(src[3]), .pin_out(pin_out), .pin_oe(pin_oe));
    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", reg_rdata, exp);
    endtask
    // three edges: one to launch the sources, then two before the pins are checked
    task automatic pins(input logic [3:0] s, input logic [4:0] go, ge, eo, ee);
        @(posedge clk);
        src      <= s;
        gpio_out <= go;
        gpio_oe  <= ge;
        repeat (2) @(posedge clk);
        #1 chk("pin_out", {3'h0, pin_out}, {3'h0, eo});
        chk("pin_oe", {3'h0, pin_oe}, {3'h0, ee});
    endtask
    task automatic end_of_test;
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rd(pin_mux_pkg::OFS_SEL_10_11, 8'h00);
        pins(4'hF, 5'h15, 5'h0A, 5'h15, 5'h0A);
        wr(pin_mux_pkg::OFS_SEL_8_9, 8'h41);
        wr(pin_mux_pkg::OFS_SEL_10_11, 8'h05);
        wr(pin_mux_pkg::OFS_SEL_12, 8'h06);
        rd(pin_mux_pkg::OFS_SEL_8_9, 8'h41);
        rd(pin_mux_pkg::OFS_SEL_10_11, 8'h05);
        rd(pin_mux_pkg::OFS_SEL_12, 8'h06);
        rd(9'h1A7, 8'h00);
        pins(4'h5, 5'h08, 5'h00, 5'h0D, 5'h17);
        pins(4'hA, 5'h17, 5'h1F, 5'h12, 5'h1F);
        wr(pin_mux_pkg::OFS_SEL_8_9, 8'h60);
        rd(pin_mux_pkg::OFS_SEL_8_9, 8'h60);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(pin_mux_pkg::OFS_SEL_8_9, 8'h00);
        pins(4'hF, 5'h0A, 5'h15, 5'h0A, 5'h15);
        end_of_test();
    end
endmodule
